// ### design/ccrb_bank.sv
// Write-only configuration and parameter bank with registered decodes.
// Assumes the serial decoder delivers one whole word per write strobe,
// and the OTP loader delivers the protected byte with its own strobe.
//
// What this block does
// [RL1] Bits 19:18 of word 0 set compare length
// [RL2] Error repair mode decoded with byte limit
// [RL3] Boot nibble 0 stand-alone, F slave boot
// [RL4] Lock nibble 0 blocks readout, F unblocked
// [RL5] Word 0 low byte only from OTP
// [RL6] Trim field selects oscillator frequency
// [RL7] One enable bit per port from bit 16
// [RL8] Wiring scheme decode; differential needs parameter
// [RL9] Mirror charge bit enables symmetric charging
// [RL10] External parasitic compensation off when set
// [RL11] Internal parasitic compensation off when set
// [RL12] Three-bit code selects discharge resistor
// [RL13] Two-bit field selects stray compensation
// [RL14] Pulse select, slopes, offsets at 13-17
// [RL15] Differential flag 18, gain word 19
// [RL16] Words write-only; no read path exists
`timescale 1ns/10ps

module ccrb_bank
  import ccrb_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 8  // Capacitance ports in the mask
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Host word writes
  input ccrb_pkg::ccrb_wr_t host_wr,
  // OTP copy of the protected byte
  input wire logic otp_byte_load,
  input wire logic [7:0] otp_byte,
  // Decoded settings
  output ccrb_pkg::ccrb_cfg_t cfg_q,
  output logic [NUM_PORTS-1:0] cap_port_mask_q,
  // Firmware parameter words
  output logic [23:0] pulse_source_select_q,
  output logic [23:0] pulse_a_slope_q,
  output logic [23:0] pulse_a_offset_q,
  output logic [23:0] pulse_b_slope_q,
  output logic [23:0] pulse_b_offset_q,
  output logic [23:0] differential_select_q,
  output logic [23:0] gain_correction_q,
  // Raw hardware words 0 to 10 for the remaining consumers
  output logic [10:0][23:0] hw_word_q
);

  import ccrb_pkg::*;

  // ****************************************
  // Storage
  // ****************************************

  // One flip-flop word per address
  logic [CCRB_NUM_WORDS-1:0][CCRB_DATA_W-1:0] word_q;
  // Write hit on a stored address
  logic wr_hit;

  // ****************************************
  // Decode functions
  // ****************************************

  // Compare length in bytes from the two-bit field
  function automatic logic [8:0] cmp_len(input logic [1:0] code);
    logic [8:0] len;
    len = 9'h000;
    case (code)
      2'h1: len = CMP_LEN_1;
      2'h2: len = CMP_LEN_2;
      2'h3: len = CMP_LEN_3;
      default: len = 9'h000;
    endcase
    return len;
  endfunction : cmp_len

  // Error repair mode from its byte
  function automatic ccrb_ecc_t ecc_mode(input logic [7:0] code);
    ccrb_ecc_t m;
    m = ECC_M_BAD;
    case (code)
      ECC_SINGLE: m = ECC_M_SINGLE;
      ECC_DOUBLE: m = ECC_M_DOUBLE;
      ECC_QUAD: m = ECC_M_QUAD;
      default: m = ECC_M_BAD;
    endcase
    return m;
  endfunction : ecc_mode

  // Oscillator frequency in kHz, zero for an unlisted trim
  function automatic logic [7:0] osc_khz(input logic [5:0] trim);
    logic [7:0] f;
    f = 8'h00;
    case (trim)
      TRIM_10K: f = KHZ_10;
      TRIM_50K: f = KHZ_50;
      TRIM_100K: f = KHZ_100;
      TRIM_200K: f = KHZ_200;
      default: f = 8'h00;
    endcase
    return f;
  endfunction : osc_khz

  // Discharge resistor in kOhm, zero for an unlisted code
  function automatic logic [7:0] rdchg_kohm(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      RDCHG_180K: r = KOHM_180;
      RDCHG_90K: r = KOHM_90;
      RDCHG_30K: r = KOHM_30;
      RDCHG_10K: r = KOHM_10;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rdchg_kohm

  // ****************************************
  // Word writes
  // ****************************************

  // Only addresses 0 to 20 are stored; others fall away
  assign wr_hit = host_wr.en && (host_wr.addr <= ADDR_RUN_CONTROL);

  // Host writes and the OTP byte copy
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CCRB_NUM_WORDS; i++) begin
        word_q[i] <= RST_WORD;
      end
      word_q[ADDR_OSCILLATOR_TRIM_CONFIG] <= RST_OSCILLATOR_TRIM;
    end else begin
      // Host write; protected byte kept
      if (wr_hit) begin
        if (host_wr.addr == ADDR_OTP_BOOT_CONFIG) begin
          word_q[ADDR_OTP_BOOT_CONFIG][CCRB_DATA_W-1:F_SECRET_MSB+1] <=
            host_wr.data[CCRB_DATA_W-1:F_SECRET_MSB+1]; // RL5
        end else begin
          word_q[host_wr.addr] <= host_wr.data; // RL14 RL15
        end
      end
      // OTP copy is the only way into the low byte
      if (otp_byte_load) begin
        word_q[ADDR_OTP_BOOT_CONFIG][F_SECRET_MSB:0] <= otp_byte; // RL5
      end
    end
  end

  // ****************************************
  // Registered decodes
  // ****************************************

  // OTP and boot settings from word 0
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_q.cmp_len_bytes <= 9'h000;
      cfg_q.ecc_mode <= ECC_M_SINGLE;
      cfg_q.ecc_limit_bytes <= ECC_LIMIT_FULL;
      cfg_q.stand_alone <= 1'b1;
      cfg_q.readout_blocked <= 1'b1;
    end else begin
      cfg_q.cmp_len_bytes <=
        cmp_len(word_q[ADDR_OTP_BOOT_CONFIG][F_CMP_LEN_LSB+:2]); // RL1
      cfg_q.ecc_mode <= ecc_mode(word_q[ADDR_OTP_BOOT_CONFIG][F_ECC_LSB+:8]); // RL2
      // Quad mode cuts the usable size to 1984 bytes
      if (ecc_mode(word_q[ADDR_OTP_BOOT_CONFIG][F_ECC_LSB+:8]) == ECC_M_QUAD) begin
        cfg_q.ecc_limit_bytes <= ECC_LIMIT_QUAD; // RL2
      end else begin
        cfg_q.ecc_limit_bytes <= ECC_LIMIT_FULL; // RL2
      end
      // Only full F means slave boot
      cfg_q.stand_alone <=
        (word_q[ADDR_OTP_BOOT_CONFIG][F_BOOT_LSB+:4] != NIBBLE_SET); // RL3
      // Only full F releases the readout blocker
      cfg_q.readout_blocked <=
        (word_q[ADDR_OTP_BOOT_CONFIG][F_LOCK_LSB+:4] != NIBBLE_SET); // RL4
    end
  end

  // Oscillator trim from word 1
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_q.osc_khz <= KHZ_50;
      cfg_q.osc_trim_valid <= 1'b1;
    end else begin
      cfg_q.osc_khz <= osc_khz(word_q[ADDR_OSCILLATOR_TRIM_CONFIG][F_TRIM_LSB+:6]); // RL6
      cfg_q.osc_trim_valid <=
        (osc_khz(word_q[ADDR_OSCILLATOR_TRIM_CONFIG][F_TRIM_LSB+:6]) != 8'h00); // RL6
    end
  end

  // Capacitance port setup from word 2
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cap_port_mask_q <= '0;
      cfg_q.wiring <= WIRE_GROUNDED;
      cfg_q.mirror_charge <= 1'b0;
      cfg_q.ext_comp_active <= 1'b1;
      cfg_q.int_comp_active <= 1'b1;
      cfg_q.discharge_kohm <= 8'h00;
      cfg_q.discharge_valid <= 1'b0;
      cfg_q.stray <= STRAY_BOTH;
    end else begin
      // Bit 16 is port zero, upward from there
      cap_port_mask_q <= word_q[ADDR_CAP_PORT_CONFIG][F_PORT_LSB+:NUM_PORTS]; // RL7
      cfg_q.wiring <= ccrb_wiring_t'(word_q[ADDR_CAP_PORT_CONFIG][F_SCHEME_LSB+:2]); // RL8
      cfg_q.mirror_charge <= word_q[ADDR_CAP_PORT_CONFIG][F_MIRROR_BIT]; // RL9
      // Disable bit and stray choice must both allow a measurement
      cfg_q.ext_comp_active <= !word_q[ADDR_CAP_PORT_CONFIG][F_EXT_OFF_BIT] && // RL10
        (word_q[ADDR_CAP_PORT_CONFIG][F_STRAY_LSB+:2] inside {STRAY_BOTH,
        STRAY_EXT_ONLY}); // RL13
      cfg_q.int_comp_active <= !word_q[ADDR_CAP_PORT_CONFIG][F_INT_OFF_BIT] && // RL11
        (word_q[ADDR_CAP_PORT_CONFIG][F_STRAY_LSB+:2] inside {STRAY_BOTH,
        STRAY_INT_ONLY}); // RL13
      cfg_q.discharge_kohm <= rdchg_kohm(word_q[ADDR_CAP_PORT_CONFIG][F_RDCHG_LSB+:3]); // RL12
      cfg_q.discharge_valid <=
        (rdchg_kohm(word_q[ADDR_CAP_PORT_CONFIG][F_RDCHG_LSB+:3]) != 8'h00); // RL12
      cfg_q.stray <= ccrb_stray_t'(word_q[ADDR_CAP_PORT_CONFIG][F_STRAY_LSB+:2]); // RL13
    end
  end

  // Run flag and the differential consistency check
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_q.run_flag <= 1'b0;
      cfg_q.diff_param_missing <= 1'b0;
    end else begin
      cfg_q.run_flag <= word_q[ADDR_RUN_CONTROL][F_RUN_BIT];
      // Floating differential wiring without the differential parameter
      cfg_q.diff_param_missing <=
        (word_q[ADDR_CAP_PORT_CONFIG][F_SCHEME_LSB+:2] == WIRE_FLOAT_DIFF) &&
        (word_q[ADDR_DIFFERENTIAL_SELECT] == RST_WORD); // RL8
    end
  end

  // ****************************************
  // Word outputs
  // ****************************************

  // Firmware parameters and raw hardware words, one cycle behind storage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulse_source_select_q <= RST_WORD;
      pulse_a_slope_q <= RST_WORD;
      pulse_a_offset_q <= RST_WORD;
      pulse_b_slope_q <= RST_WORD;
      pulse_b_offset_q <= RST_WORD;
      differential_select_q <= RST_WORD;
      gain_correction_q <= RST_WORD;
      for (int i = 0; i < 11; i++) begin
        hw_word_q[i] <= RST_WORD;
      end
      hw_word_q[ADDR_OSCILLATOR_TRIM_CONFIG] <= RST_OSCILLATOR_TRIM;
    end else begin
      pulse_source_select_q <= word_q[ADDR_PULSE_SOURCE_SELECT]; // RL14
      pulse_a_slope_q <= word_q[ADDR_PULSE_A_SLOPE]; // RL14
      pulse_a_offset_q <= word_q[ADDR_PULSE_A_OFFSET]; // RL14
      pulse_b_slope_q <= word_q[ADDR_PULSE_B_SLOPE]; // RL14
      pulse_b_offset_q <= word_q[ADDR_PULSE_B_OFFSET]; // RL14
      differential_select_q <= word_q[ADDR_DIFFERENTIAL_SELECT]; // RL15
      gain_correction_q <= word_q[ADDR_GAIN_CORRECTION]; // RL15
      for (int i = 0; i < 11; i++) begin
        hw_word_q[i] <= word_q[i];
      end
    end
  end

  // No read port: the words cannot be read back over the host link. RL16

endmodule : ccrb_bank

// ### pkg/ccrb_pkg.sv
// Constants and carrier types for the write-only configuration bank.
// Assumes a serial host decoder that presents whole 24-bit words.
package ccrb_pkg;

  // ****************************************
  // Map geometry
  // ****************************************
  localparam int unsigned CCRB_ADDR_W = 5;   // Word address width
  localparam int unsigned CCRB_DATA_W = 24;  // Configuration word width
  localparam int unsigned CCRB_NUM_WORDS = 21; // Addresses 0 to 20

  // Word addresses
  localparam logic [4:0] ADDR_OTP_BOOT_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_OSCILLATOR_TRIM_CONFIG = 5'h01;
  localparam logic [4:0] ADDR_CAP_PORT_CONFIG = 5'h02;
  localparam logic [4:0] ADDR_UNUSED_PARAM_A = 5'h0b;
  localparam logic [4:0] ADDR_UNUSED_PARAM_B = 5'h0c;
  localparam logic [4:0] ADDR_PULSE_SOURCE_SELECT = 5'h0d;
  localparam logic [4:0] ADDR_PULSE_A_SLOPE = 5'h0e;
  localparam logic [4:0] ADDR_PULSE_A_OFFSET = 5'h0f;
  localparam logic [4:0] ADDR_PULSE_B_SLOPE = 5'h10;
  localparam logic [4:0] ADDR_PULSE_B_OFFSET = 5'h11;
  localparam logic [4:0] ADDR_DIFFERENTIAL_SELECT = 5'h12;
  localparam logic [4:0] ADDR_GAIN_CORRECTION = 5'h13;
  localparam logic [4:0] ADDR_RUN_CONTROL = 5'h14;

  // Reset values
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [23:0] RST_OSCILLATOR_TRIM = 24'h201022;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned F_CMP_LEN_LSB = 18; // Compare length, 2 bits
  localparam int unsigned F_ECC_LSB = 8;      // Error repair mode, 8 bits
  localparam int unsigned F_BOOT_LSB = 4;     // Self-boot inhibit, 4 bits
  localparam int unsigned F_LOCK_LSB = 0;     // Readout-block inhibit, 4 bits
  localparam int unsigned F_SECRET_MSB = 7;   // OTP-only byte top bit
  localparam int unsigned F_TRIM_LSB = 0;     // Oscillator trim, 6 bits
  localparam int unsigned F_PORT_LSB = 16;    // Port mask base bit
  localparam int unsigned F_SCHEME_LSB = 14;  // Wiring scheme, 2 bits
  localparam int unsigned F_MIRROR_BIT = 10;  // Mirror charge enable
  localparam int unsigned F_EXT_OFF_BIT = 9;  // External parasitic comp off
  localparam int unsigned F_INT_OFF_BIT = 8;  // Internal parasitic comp off
  localparam int unsigned F_RDCHG_LSB = 4;    // Discharge resistor, 3 bits
  localparam int unsigned F_STRAY_LSB = 0;    // Stray compensation, 2 bits
  localparam int unsigned F_RUN_BIT = 0;      // Run flag

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [7:0] ECC_SINGLE = 8'h00;
  localparam logic [7:0] ECC_DOUBLE = 8'h0f;
  localparam logic [7:0] ECC_QUAD = 8'hf0;
  localparam logic [11:0] ECC_LIMIT_FULL = 12'hfc0;  // 4032 bytes
  localparam logic [11:0] ECC_LIMIT_QUAD = 12'h7c0;  // 1984 bytes
  localparam logic [3:0] NIBBLE_CLEAR = 4'h0;
  localparam logic [3:0] NIBBLE_SET = 4'hf;

  localparam logic [8:0] CMP_LEN_1 = 9'h005; // 5 bytes
  localparam logic [8:0] CMP_LEN_2 = 9'h021; // 33 bytes
  localparam logic [8:0] CMP_LEN_3 = 9'h101; // 257 bytes

  localparam logic [5:0] TRIM_10K = 6'h35;
  localparam logic [5:0] TRIM_50K = 6'h22;
  localparam logic [5:0] TRIM_100K = 6'h13;
  localparam logic [5:0] TRIM_200K = 6'h04;
  localparam logic [7:0] KHZ_10 = 8'h0a;
  localparam logic [7:0] KHZ_50 = 8'h32;
  localparam logic [7:0] KHZ_100 = 8'h64;
  localparam logic [7:0] KHZ_200 = 8'hc8;

  localparam logic [2:0] RDCHG_180K = 3'h4;
  localparam logic [2:0] RDCHG_90K = 3'h5;
  localparam logic [2:0] RDCHG_30K = 3'h6;
  localparam logic [2:0] RDCHG_10K = 3'h7;
  localparam logic [7:0] KOHM_180 = 8'hb4;
  localparam logic [7:0] KOHM_90 = 8'h5a;
  localparam logic [7:0] KOHM_30 = 8'h1e;
  localparam logic [7:0] KOHM_10 = 8'h0a;

  // Sensor wiring scheme
  typedef enum logic [1:0] {
    WIRE_GROUNDED = 2'h0,
    WIRE_FLOAT_SINGLE = 2'h1,
    WIRE_FLOAT_DIFF = 2'h2,
    WIRE_UNDEFINED = 2'h3
  } ccrb_wiring_t;

  // Stray compensation choice
  typedef enum logic [1:0] {
    STRAY_BOTH = 2'h0,
    STRAY_EXT_ONLY = 2'h1,
    STRAY_INT_ONLY = 2'h2,
    STRAY_NONE = 2'h3
  } ccrb_stray_t;

  // Error repair mode, one-hot
  typedef enum logic [3:0] {
    ECC_M_SINGLE = 4'b0001,
    ECC_M_DOUBLE = 4'b0010,
    ECC_M_QUAD = 4'b0100,
    ECC_M_BAD = 4'b1000
  } ccrb_ecc_t;

  // Host word write strobe with data
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [23:0] data;
  } ccrb_wr_t;

  // Decoded settings for the consumers
  typedef struct packed {
    logic [8:0] cmp_len_bytes;
    ccrb_ecc_t ecc_mode;
    logic [11:0] ecc_limit_bytes;
    logic stand_alone;
    logic readout_blocked;
    logic [7:0] osc_khz;
    logic osc_trim_valid;
    ccrb_wiring_t wiring;
    logic mirror_charge;
    logic ext_comp_active;
    logic int_comp_active;
    logic [7:0] discharge_kohm;
    logic discharge_valid;
    ccrb_stray_t stray;
    logic run_flag;
    logic diff_param_missing;
  } ccrb_cfg_t;

endpackage : ccrb_pkg

// ### test/ccrb_bank_checker.sv
// Concurrent checks on the configuration bank ports, bound below.
// Assumes one clock, async high reset, outputs settle two edges after a write.
`timescale 1ns/10ps
module ccrb_bank_checker
  import ccrb_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 8  // Mask width
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Write side
  input ccrb_pkg::ccrb_wr_t host_wr,
  input wire logic otp_byte_load,
  input wire logic [7:0] otp_byte,
  // Settings
  input ccrb_pkg::ccrb_cfg_t cfg_q,
  input wire logic [NUM_PORTS-1:0] cap_port_mask_q,
  input wire logic [23:0] gain_correction_q,
  input wire logic [10:0][23:0] hw_word_q
);
  // ****************************************
  // Helpers
  // ****************************************
  logic w0, w1, w2, wg;  // Host writes to words 0, 1, 2, 19
  logic [23:0] d1_q, d2_q;  // Host data, two edges old
  logic [7:0] o1_q, o2_q;  // OTP byte, two edges old
  assign w0 = host_wr.en && host_wr.addr == ADDR_OTP_BOOT_CONFIG;
  assign w1 = host_wr.en && host_wr.addr == ADDR_OSCILLATOR_TRIM_CONFIG;
  assign w2 = host_wr.en && host_wr.addr == ADDR_CAP_PORT_CONFIG;
  assign wg = host_wr.en && host_wr.addr == ADDR_GAIN_CORRECTION;
  // Delay lines line cause up with effect
  always_ff @(posedge core_clk) begin
    d1_q <= host_wr.data;
    d2_q <= d1_q;
    o1_q <= otp_byte;
    o2_q <= o1_q;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // ****************************************
  // Properties
  // ****************************************
  property p_cmp_len;
    w0 |-> ##2 cfg_q.cmp_len_bytes == (d2_q[19:18] == 2'h0 ? 9'h000 : d2_q[19:18] == 2'h1 ?
      9'h005 : d2_q[19:18] == 2'h2 ? 9'h021 : 9'h101);
  endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare length wrong");
  property p_ecc;
    w0 |-> ##2 cfg_q.ecc_limit_bytes == (d2_q[15:8] == 8'hf0 ? 12'h7c0 : 12'hfc0);
  endproperty
  a_ecc: assert property (p_ecc) else $error("repair limit wrong");
  property p_secret;
    !otp_byte_load |-> ##2 $stable(hw_word_q[0][7:0]);
  endproperty
  a_secret: assert property (p_secret) else $error("protected byte moved");
  property p_boot;
    otp_byte_load |-> ##2 cfg_q.stand_alone == (o2_q[7:4] != 4'hf);
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode wrong");
  property p_lock;
    otp_byte_load |-> ##2 cfg_q.readout_blocked == (o2_q[3:0] != 4'hf);
  endproperty
  a_lock: assert property (p_lock) else $error("readout block wrong");
  property p_trim;
    w1 |-> ##2 cfg_q.osc_khz == (d2_q[5:0] == 6'h35 ? 8'h0a : d2_q[5:0] == 6'h22 ? 8'h32 :
      d2_q[5:0] == 6'h13 ? 8'h64 : d2_q[5:0] == 6'h04 ? 8'hc8 : 8'h00);
  endproperty
  a_trim: assert property (p_trim) else $error("oscillator rate wrong");
  property p_mask;
    w2 |-> ##2 cap_port_mask_q == d2_q[16 +: NUM_PORTS];
  endproperty
  a_mask: assert property (p_mask) else $error("port mask wrong");
  property p_wiring;
    w2 |-> ##2 cfg_q.wiring == d2_q[15:14] && cfg_q.mirror_charge == d2_q[10];
  endproperty
  a_wiring: assert property (p_wiring) else $error("wiring or mirror wrong");
  property p_comp;
    w2 |-> ##2 cfg_q.ext_comp_active == (!d2_q[9] && !d2_q[1]) &&
      cfg_q.int_comp_active == (!d2_q[8] && !d2_q[0]);
  endproperty
  a_comp: assert property (p_comp) else $error("compensation wrong");
  property p_rdchg;
    w2 |-> ##2 cfg_q.discharge_kohm == (d2_q[6:4] == 3'h4 ? 8'hb4 : d2_q[6:4] == 3'h5 ?
      8'h5a : d2_q[6:4] == 3'h6 ? 8'h1e : d2_q[6:4] == 3'h7 ? 8'h0a : 8'h00);
  endproperty
  a_rdchg: assert property (p_rdchg) else $error("discharge resistor wrong");
  property p_gain;
    wg |-> ##2 gain_correction_q == d2_q;
  endproperty
  a_gain: assert property (p_gain) else $error("gain word wrong");
endmodule : ccrb_bank_checker

bind ccrb_bank ccrb_bank_checker #(.NUM_PORTS(NUM_PORTS)) u_checker (
  .core_clk(core_clk),
  .reset(reset),
  .host_wr(host_wr),
  .otp_byte_load(otp_byte_load),
  .otp_byte(otp_byte),
  .cfg_q(cfg_q),
  .cap_port_mask_q(cap_port_mask_q),
  .gain_correction_q(gain_correction_q),
  .hw_word_q(hw_word_q)
);

// ### test/ccrb_host_model.sv
// Host writer model for the configuration bank.
// Assumes the bench calls put once per cycle, from one process.
`timescale 1ns/10ps
module ccrb_host_model
  import ccrb_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Word writes
  output ccrb_pkg::ccrb_wr_t host_wr
);
  initial begin
    host_wr = '0;
  end
  // Write-only host: no read path, idle cycles scramble the lines
  task automatic put(input logic en, input logic [4:0] addr, input logic [23:0] data);
    @(negedge core_clk);
    if (en) begin
      host_wr <= '{en: 1'b1, addr: addr, data: data};
    end else begin
      host_wr <= '{en: 1'b0, addr: ~host_wr.addr, data: ~host_wr.data};
    end
  endtask : put
endmodule : ccrb_host_model

// ### test/tb_top.sv
// Self-checking bench for the configuration bank.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
module tb_top;
  import ccrb_pkg::*;
  logic core_clk = 1'b0;  // 25 MHz clock
  logic reset = 1'b1;  // Async reset
  logic otp_byte_load = 1'b0;  // OTP copy strobe
  logic [7:0] otp_byte = 8'h00;  // OTP byte
  ccrb_wr_t host_wr;  // From host model
  ccrb_cfg_t cfg_q;  // Decoded settings
  logic [7:0] cap_port_mask_q;  // Port enables
  logic [6:0][23:0] par_q;  // Words 13 to 19
  logic [10:0][23:0] hw_word_q;  // Words 0 to 10
  int mismatches = 0;
  int compares = 0;
  ccrb_host_model host (.core_clk(core_clk), .host_wr(host_wr));
  ccrb_bank #(.NUM_PORTS(8)) dut (
    .core_clk(core_clk),
    .reset(reset),
    .host_wr(host_wr),
    .otp_byte_load(otp_byte_load),
    .otp_byte(otp_byte),
    .cfg_q(cfg_q),
    .cap_port_mask_q(cap_port_mask_q),
    .pulse_source_select_q(par_q[0]),
    .pulse_a_slope_q(par_q[1]),
    .pulse_a_offset_q(par_q[2]),
    .pulse_b_slope_q(par_q[3]),
    .pulse_b_offset_q(par_q[4]),
    .differential_select_q(par_q[5]),
    .gain_correction_q(par_q[6]),
    .hw_word_q(hw_word_q)
  );
  // Clock and hang guard
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(40 * 5000);
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One word, then wait until outputs settle
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    host.put(1'b1, a, d);
    host.put(1'b0, 5'h00, 24'h000000);
    @(negedge core_clk);
  endtask : wr
  task automatic t_reset();
    chk(hw_word_q[1], RST_OSCILLATOR_TRIM);
    chk(cfg_q.osc_khz, 8'h32);
    chk({cfg_q.stand_alone, cfg_q.readout_blocked}, 24'h000003);
  endtask : t_reset
  task automatic t_word0();
    logic [7:0] ecc [4] = '{8'h00, 8'h0f, 8'hf0, 8'h3c};
    logic [11:0] lim [4] = '{12'hfc0, 12'hfc0, 12'h7c0, 12'hfc0};
    logic [3:0] mode [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [8:0] len [4] = '{9'h000, 9'h005, 9'h021, 9'h101};
    logic [23:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {4'h0, 2'(i), 2'h0, ecc[i], 8'hff};
      wr(ADDR_OTP_BOOT_CONFIG, d);
      chk(cfg_q.cmp_len_bytes, len[i]);
      chk(cfg_q.ecc_limit_bytes, lim[i]);
      chk(cfg_q.ecc_mode, mode[i]);
      chk(hw_word_q[0], {d[23:8], 8'h00});
      chk(cfg_q.stand_alone, 1'b1);
    end
  endtask : t_word0
  // OTP byte copied in the same cycle as a host write to word 0
  task automatic t_otp();
    logic [7:0] b [3] = '{8'hff, 8'hf5, 8'h0f};
    for (int i = 0; i < 3; i++) begin
      host.put(1'b1, ADDR_OTP_BOOT_CONFIG, 24'h0c0faa);
      otp_byte_load = 1'b1;
      otp_byte = b[i];
      host.put(1'b0, 5'h00, 24'h000000);
      otp_byte_load = 1'b0;
      otp_byte = ~b[i];
      @(negedge core_clk);
      chk(hw_word_q[0], {16'h0c0f, b[i]});
      chk(cfg_q.stand_alone, b[i][7:4] != 4'hf);
      chk(cfg_q.readout_blocked, b[i][3:0] != 4'hf);
    end
  endtask : t_otp
  task automatic t_trim();
    logic [5:0] code [5] = '{6'h35, 6'h22, 6'h13, 6'h04, 6'h3f};
    logic [7:0] khz [5] = '{8'h0a, 8'h32, 8'h64, 8'hc8, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_OSCILLATOR_TRIM_CONFIG, {18'h00000, code[i]});
      chk(cfg_q.osc_khz, khz[i]);
      chk(cfg_q.osc_trim_valid, i < 4);
    end
  endtask : t_trim
  task automatic t_port();
    logic [7:0] kohm [4] = '{8'hb4, 8'h5a, 8'h1e, 8'h0a};
    logic [7:0] m;
    logic [1:0] s;
    logic xo;
    logic io;
    logic [23:0] d;
    for (int i = 0; i < 4; i++) begin
      m = 8'(8'h81 << i);
      s = 2'(i);
      xo = (i == 1);
      io = (i == 2);
      d = {m, s, 3'h0, s[0], xo, io, 1'b0, 3'(4 + i), 2'h0, s};
      wr(ADDR_CAP_PORT_CONFIG, d);
      chk(cap_port_mask_q, m);
      chk(hw_word_q[2], d);
      chk(cfg_q.wiring, s);
      chk(cfg_q.diff_param_missing, i == 2);
      chk(cfg_q.mirror_charge, s[0]);
      chk(cfg_q.ext_comp_active, !xo && !s[1]);
      chk(cfg_q.int_comp_active, !io && !s[0]);
      chk(cfg_q.discharge_kohm, kohm[i]);
      chk(cfg_q.discharge_valid, 1'b1);
      chk(cfg_q.stray, s);
    end
  endtask : t_port
  // Back-to-back parameter words, the run-control word, then two unmapped addresses
  task automatic t_params();
    for (int i = 0; i < 7; i++) begin
      host.put(1'b1, 5'(13 + i), 24'h5a0000 + 24'(i * 257));
    end
    host.put(1'b1, ADDR_RUN_CONTROL, 24'h000001);
    host.put(1'b1, 5'h15, 24'hffffff);
    host.put(1'b1, 5'h1f, 24'hffffff);
    host.put(1'b0, 5'h00, 24'h000000);
    @(negedge core_clk);
    for (int i = 0; i < 7; i++) begin
      chk(par_q[i], 24'h5a0000 + 24'(i * 257));
    end
    chk(cfg_q.run_flag, 1'b1);
    chk(hw_word_q[5], 24'h000000);
    wr(ADDR_CAP_PORT_CONFIG, 24'h008000);
    chk(cfg_q.diff_param_missing, 1'b0);
    chk(cfg_q.discharge_kohm, 8'h00);
    chk(cfg_q.discharge_valid, 1'b0);
  endtask : t_params
  // Reset in mid-run returns written settings to their reset values
  task automatic t_midreset();
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    chk(par_q[6], RST_WORD);
    chk(hw_word_q[2], RST_WORD);
    chk(cfg_q.run_flag, 1'b0);
  endtask : t_midreset
  // Main sequence
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_word0();
    t_otp();
    t_trim();
    t_port();
    t_params();
    t_midreset();
    tally_and_finish();
  end
endmodule : tb_top
